// ### hw/cilr_regs.sv
`timescale 1ns/1ps
`default_nettype none

module cilr_regs (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        reg_rst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n_o,
    output logic [5:0]       input_current_limit_code_o,
    output logic [11:0]      input_current_limit_ma_o,
    output logic [1:0]       status_indicator_select_o,
    output logic             indicator_charging_o,
    output logic             indicator_forced_o
);

    typedef struct packed {
        cilr_pkg::cilr_state_t st;
        logic                  scl_p;
        logic                  sda_p;
        logic [7:0]            shreg;
        logic [3:0]            bitcnt;
        logic [7:0]            ptr;
        logic                  have_ptr;
        logic                  rw;
        logic                  drive;
        logic [7:0]            icl;
        logic [11:0]           ma;
        logic                  chg;
        logic                  frc;
    } cilr_regs_t;

    cilr_regs_t q, d;
    logic [1:0] pins_s;
    logic       scl_s;
    logic       sda_s;

    cilr_sync #(
        .W (2)
    ) u_sync (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .async_i ({scl_i, sda_i}),
        .sync_o  (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    function automatic logic [7:0] read_data(
        input logic [7:0] ptr,
        input logic [7:0] icl
    );
        logic [7:0] r;
        r = cilr_pkg::UNIMPL_DATA;
        if (ptr == cilr_pkg::ICL_OFFSET) begin
            r = icl;
        end else if (ptr > cilr_pkg::LAST_OFFSET) begin
            r = cilr_pkg::BEYOND_DATA;
        end
        return r;
    endfunction : read_data

    function automatic logic [5:0] clamp_code(input logic [5:0] c);
        return (c > cilr_pkg::CODE_MAX) ? cilr_pkg::CODE_MAX : c;
    endfunction : clamp_code

    function automatic logic [11:0] code_to_ma(input logic [5:0] c);
        logic [17:0] p;
        p = 18'({12'h000, c} * cilr_pkg::MA_STEP);
        return 12'(p[11:0] + cilr_pkg::MA_OFFSET);
    endfunction : code_to_ma

    function automatic logic sel_is(
        input logic [7:0] r,
        input logic [1:0] s
    );
        return (r[cilr_pkg::SEL_MSB:cilr_pkg::SEL_LSB] == s);
    endfunction : sel_is

    always_comb begin
        logic start_ev;
        logic stop_ev;
        logic rise;
        logic fall;
        logic [7:0] rd;
        start_ev = q.scl_p & scl_s & q.sda_p & ~sda_s;
        stop_ev  = q.scl_p & scl_s & ~q.sda_p & sda_s;
        rise     = ~q.scl_p & scl_s;
        fall     = q.scl_p & ~scl_s;
        rd       = read_data(q.ptr, q.icl);
        d        = q;
        d.scl_p  = scl_s;
        d.sda_p  = sda_s;

        if (start_ev) begin
            // Repeated start keeps the pointer set by the write phase
            d.st       = cilr_pkg::CILR_ADDR;
            d.bitcnt   = 4'h0;
            d.drive    = 1'b0;
            d.have_ptr = 1'b0;
        end else if (stop_ev) begin
            d.st    = cilr_pkg::CILR_IDLE;
            d.drive = 1'b0;
        end else if (rise) begin
            case (q.st)
                cilr_pkg::CILR_ADDR,
                cilr_pkg::CILR_WR_BYTE: begin
                    d.shreg  = {q.shreg[6:0], sda_s};
                    d.bitcnt = 4'(q.bitcnt + 4'h1);
                end
                cilr_pkg::CILR_RD_BYTE: begin
                    d.bitcnt = 4'(q.bitcnt + 4'h1);
                end
                cilr_pkg::CILR_RD_ACK: begin
                    // master ACK advances to next register
                    if (!sda_s) begin
                        d.ptr = 8'(q.ptr + 8'h01);
                    end else begin
                        d.st = cilr_pkg::CILR_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (fall) begin
            case (q.st)
                cilr_pkg::CILR_ADDR: begin
                    if (q.bitcnt == cilr_pkg::BYTE_BITS) begin
                        if (q.shreg[7:1] == cilr_pkg::SLAVE_ADDR) begin
                            d.drive = 1'b1;
                            d.rw    = q.shreg[0];
                            d.st    = cilr_pkg::CILR_ADDR_ACK;
                        end else begin
                            d.st = cilr_pkg::CILR_IDLE;
                        end
                    end
                end
                cilr_pkg::CILR_ADDR_ACK,
                cilr_pkg::CILR_WR_ACK: begin
                    d.bitcnt = 4'h0;
                    if (q.st == cilr_pkg::CILR_ADDR_ACK && q.rw) begin
                        d.shreg = rd;
                        d.drive = ~rd[7];
                        d.st    = cilr_pkg::CILR_RD_BYTE;
                    end else begin
                        d.drive = 1'b0;
                        d.st    = cilr_pkg::CILR_WR_BYTE;
                    end
                end
                cilr_pkg::CILR_WR_BYTE: begin
                    if (q.bitcnt == cilr_pkg::BYTE_BITS) begin
                        d.drive = 1'b1;
                        d.st    = cilr_pkg::CILR_WR_ACK;
                        if (!q.have_ptr) begin
                            d.ptr      = q.shreg;
                            d.have_ptr = 1'b1;
                        end else begin
                            if (q.ptr == cilr_pkg::ICL_OFFSET) begin
                                // clamp code, select stored as is
                                d.icl = {q.shreg[7:6],
                                         clamp_code(q.shreg[5:0])};
                            end
                            // next data byte to next register
                            d.ptr = 8'(q.ptr + 8'h01);
                        end
                    end
                end
                cilr_pkg::CILR_RD_BYTE: begin
                    if (q.bitcnt == cilr_pkg::BYTE_BITS) begin
                        d.drive = 1'b0;
                        d.st    = cilr_pkg::CILR_RD_ACK;
                    end else begin
                        d.shreg = {q.shreg[6:0], 1'b0};
                        d.drive = ~q.shreg[6];
                    end
                end
                cilr_pkg::CILR_RD_ACK: begin
                    // Only reached after ACK; NACK already went idle
                    d.shreg  = rd;
                    d.drive  = ~rd[7];
                    d.bitcnt = 4'h0;
                    d.st     = cilr_pkg::CILR_RD_BYTE;
                end
                default: begin
                end
            endcase
        end

        if (reg_rst_i) begin
            d.icl = cilr_pkg::ICL_RESET;
        end
        d.ma = code_to_ma(d.icl[cilr_pkg::CODE_MSB:cilr_pkg::CODE_LSB]);
        d.chg = sel_is(d.icl, cilr_pkg::SEL_CHARGING);
        d.frc = sel_is(d.icl, cilr_pkg::SEL_FORCED);
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q.st       <= cilr_pkg::CILR_IDLE;
            q.scl_p    <= 1'b1;
            q.sda_p    <= 1'b1;
            q.shreg    <= 8'h00;
            q.bitcnt   <= 4'h0;
            q.ptr      <= 8'h00;
            q.have_ptr <= 1'b0;
            q.rw       <= 1'b0;
            q.drive    <= 1'b0;
            q.icl      <= cilr_pkg::ICL_RESET;
            q.ma       <= code_to_ma(
                cilr_pkg::ICL_RESET[cilr_pkg::CODE_MSB:cilr_pkg::CODE_LSB]);
            q.chg      <= sel_is(cilr_pkg::ICL_RESET, cilr_pkg::SEL_CHARGING);
            q.frc      <= sel_is(cilr_pkg::ICL_RESET, cilr_pkg::SEL_FORCED);
        end else if (ce_i) begin
            q <= d;
        end
    end

    // Open drain: only ever pulls low
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = ~q.drive;
    assign input_current_limit_code_o =
        q.icl[cilr_pkg::CODE_MSB:cilr_pkg::CODE_LSB];
    assign input_current_limit_ma_o  = q.ma;
    assign status_indicator_select_o =
        q.icl[cilr_pkg::SEL_MSB:cilr_pkg::SEL_LSB];
    assign indicator_charging_o = q.chg;
    assign indicator_forced_o   = q.frc;

endmodule : cilr_regs

`default_nettype wire

// ### hw/cilr_pkg.sv
package cilr_pkg;

    // Bus address of the bank, 7 bits before the direction bit
    localparam logic [6:0] SLAVE_ADDR      = 7'h6b;

    // Register offsets
    localparam logic [7:0] ICL_OFFSET      = 8'h00;
    localparam logic [7:0] LAST_OFFSET     = 8'h0f;

    // Input current limit register layout and reset value
    localparam logic [7:0] ICL_RESET       = 8'h17;
    localparam int         CODE_LSB        = 0;
    localparam int         CODE_MSB        = 5;
    localparam int         SEL_LSB         = 6;
    localparam int         SEL_MSB         = 7;
    localparam logic [5:0] CODE_MAX        = 6'h20;

    // Read answers outside the implemented register
    localparam logic [7:0] UNIMPL_DATA     = 8'h00;
    localparam logic [7:0] BEYOND_DATA     = 8'hff;

    // Current scale in mA: offset plus one step per code
    localparam logic [11:0] MA_OFFSET      = 12'h064;
    localparam logic [11:0] MA_STEP        = 12'h064;

    // Indicator source select codes
    localparam logic [1:0] SEL_CHARGING    = 2'h0;
    localparam logic [1:0] SEL_FORCED      = 2'h1;

    // Bits per byte on the serial link
    localparam logic [3:0] BYTE_BITS       = 4'h8;

    typedef enum {
        CILR_IDLE,
        CILR_ADDR,
        CILR_ADDR_ACK,
        CILR_WR_BYTE,
        CILR_WR_ACK,
        CILR_RD_BYTE,
        CILR_RD_ACK
    } cilr_state_t;

endpackage : cilr_pkg

// ### hw/cilr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module cilr_sync #(
    parameter int W = 2
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    // Idle bus level is high, so both stages reset high
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            meta_q <= '1;
            sync_o <= '1;
        end else if (ce_i) begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : cilr_sync

`default_nettype wire

// ### tb/cilr_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module cilr_regs_chk (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        reg_rst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    input  wire logic        sda_o,
    input  wire logic        sda_oe_n_o,
    input  wire logic [5:0]  input_current_limit_code_o,
    input  wire logic [11:0] input_current_limit_ma_o,
    input  wire logic [1:0]  status_indicator_select_o,
    input  wire logic        indicator_charging_o,
    input  wire logic        indicator_forced_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    wire logic [5:0]  cd = input_current_limit_code_o;
    wire logic [1:0]  sl = status_indicator_select_o;
    AST_MA_SCALE: assert property (
        input_current_limit_ma_o == 12'h064 + 12'h064 * {6'h00, cd})
        else $error("limit in mA off scale");
    AST_CLAMP: assert property (cd <= 6'h20)
        else $error("code above clamp");
    AST_CHG_DEC: assert property (
        indicator_charging_o == (sl == 2'h0))
        else $error("charging follow decode wrong");
    AST_FRC_DEC: assert property (
        indicator_forced_o == (sl == 2'h1))
        else $error("forced follow decode wrong");
    AST_REG_RST: assert property (
        reg_rst_i && ce_i |=> cd == 6'h17 && sl == 2'h0)
        else $error("register reset not applied");
    AST_RST_VAL: assert property (
        $fell(rst_i) |-> sda_oe_n_o && cd == 6'h17 && sl == 2'h0)
        else $error("state after reset wrong");
    AST_OE_SCL: assert property (
        $changed(sda_oe_n_o) |-> !scl_i)
        else $error("data line moved while clock high");
    AST_WR_ACK: assert property (
        $changed({sl, cd}) && !$past(reg_rst_i) |-> !sda_oe_n_o)
        else $error("register moved outside ack");
    cover property (cd == 6'h20 && !sda_oe_n_o);
    cover property (reg_rst_i);
    cover property (indicator_forced_o);
endmodule : cilr_regs_chk
bind cilr_regs cilr_regs_chk u_chk (.mclk_i, .rst_i, .ce_i, .reg_rst_i,
    .scl_i, .sda_i, .sda_o, .sda_oe_n_o, .input_current_limit_code_o,
    .input_current_limit_ma_o, .status_indicator_select_o,
    .indicator_charging_o, .indicator_forced_o);
`default_nettype wire

// ### tb/cilr_master.sv
`timescale 1ns/1ps
`default_nettype none
module cilr_master (
    input  wire logic mclk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_o
);
    // Phase length in clocks; raised to act as a slow master
    int ph = 4;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : wt
    task automatic start();
        wt(ph);
        sda_o = 1'b1;
        wt(ph);
        scl_o = 1'b1;
        wt(ph);
        sda_o = 1'b0;
        wt(ph);
        scl_o = 1'b0;
    endtask : start
    task automatic stop();
        wt(ph);
        sda_o = 1'b0;
        wt(ph);
        scl_o = 1'b1;
        wt(ph);
        sda_o = 1'b1;
    endtask : stop
    // MSB first, ninth bit the acknowledge
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            wt(ph);
            sda_o = d[i];
            wt(ph);
            scl_o = 1'b1;
            wt(2 * ph);
            q[i] = sda_i;
            scl_o = 1'b0;
        end
    endtask : xfer
endmodule : cilr_master
`default_nettype wire

// ### tb/charger_input_limit_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module charger_input_limit_regs_bench;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        reg_rst_i = 1'b0;
    logic        ce = 1'b1;
    logic        scl, m_sda, sda, sda_o, oe_n, chg, frc;
    logic [5:0]  code;
    logic [11:0] ma;
    logic [1:0]  sel;
    int          n_fail = 0;
    int          samples_checked = 0;
    // Open drain with pull-up
    assign sda = m_sda & (oe_n | sda_o);
    always #25 mclk_i = ~mclk_i;
    cilr_master m (.mclk_i, .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
    cilr_regs dut (.mclk_i, .rst_i, .ce_i(ce), .reg_rst_i, .scl_i(scl),
        .sda_i(sda), .sda_o, .sda_oe_n_o(oe_n),
        .input_current_limit_code_o(code), .input_current_limit_ma_o(ma),
        .status_indicator_select_o(sel), .indicator_charging_o(chg),
        .indicator_forced_o(frc));
    task automatic chk(input string nm, input logic [23:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask : chk
    function automatic logic [7:0] clampv(input logic [7:0] v);
        return {v[7:6], (v[5:0] > 6'h20) ? 6'h20 : v[5:0]};
    endfunction : clampv
    task automatic chk_reg(input logic [7:0] v);
        logic [7:0] c;
        c = clampv(v);
        chk("code", 24'(code), 24'(c[5:0]));
        chk("ma", 24'(ma), 24'h64 + 24'h64 * 24'(c[5:0]));
        chk("sel", 24'(sel), 24'(v[7:6]));
        chk("chg", 24'(chg), 24'(v[7:6] == 2'h0));
        chk("frc", 24'(frc), 24'(v[7:6] == 2'h1));
        chk("sda_o", 24'(sda_o), 24'h0);
    endtask : chk_reg
    task automatic bus_wr(input logic [6:0] a, input logic [7:0] p,
                          input logic [15:0] d, input int n,
                          output logic nak);
        logic [8:0] q;
        m.start();
        m.xfer({a, 1'b0, 1'b1}, q);
        nak = q[0];
        if (!nak) begin
            m.xfer({p, 1'b1}, q);
            for (int i = 0; i < n; i++) begin
                m.xfer({d[15 - 8 * i -: 8], 1'b1}, q);
            end
        end
        m.stop();
    endtask : bus_wr
    // pointer, repeated start, ACK all but last
    task automatic bus_rd(input logic [7:0] p, input int n,
                          output logic [23:0] r);
        logic [8:0] q;
        r = 24'h0;
        m.start();
        m.xfer({7'h6b, 1'b0, 1'b1}, q);
        m.xfer({p, 1'b1}, q);
        m.start();
        m.xfer({7'h6b, 1'b1, 1'b1}, q);
        for (int i = 0; i < n; i++) begin
            m.xfer({8'hff, i == n - 1}, q);
            r = {r[15:0], q[8:1]};
        end
        m.stop();
    endtask : bus_rd
    task automatic t_reset();
        logic [23:0] r;
        chk_reg(8'h17);
        bus_rd(8'h00, 1, r);
        chk("rd_rst", r, 24'h17);
        $display("test reset done");
    endtask : t_reset
    task automatic t_fields();
        logic [7:0]  v [4] = '{8'h00, 8'h5f, 8'ha0, 8'he1};
        logic        nak;
        logic [23:0] r;
        foreach (v[i]) begin
            m.ph = (i == 1) ? 12 : 4;
            bus_wr(7'h6b, 8'h00, {v[i], 8'h00}, 1, nak);
            chk("ack", 24'(nak), 24'h0);
            chk_reg(v[i]);
            bus_rd(8'h00, 1, r);
            chk("rd", r, 24'(clampv(v[i])));
        end
        $display("test fields done");
    endtask : t_fields
    task automatic t_multi();
        logic        nak;
        logic [23:0] r;
        bus_wr(7'h6b, 8'h00, 16'h3f55, 2, nak);
        chk_reg(8'h3f);
        bus_rd(8'h0e, 3, r);
        chk("walk", r, 24'h0000ff);
        bus_rd(8'h00, 2, r);
        chk("walk0", r, 24'h2000);
        $display("test multi done");
    endtask : t_multi
    task automatic t_refuse();
        logic        nak;
        logic [23:0] r;
        bus_wr(7'h6a, 8'h00, 16'h0000, 1, nak);
        chk("nak", 24'(nak), 24'h1);
        chk_reg(8'h3f);
        // Frozen block must ignore the register reset
        ce = 1'b0;
        reg_rst_i = 1'b1;
        m.wt(2);
        reg_rst_i = 1'b0;
        m.wt(1);
        ce = 1'b1;
        m.wt(1);
        chk_reg(8'h3f);
        reg_rst_i = 1'b1;
        m.wt(2);
        reg_rst_i = 1'b0;
        m.wt(1);
        chk_reg(8'h17);
        bus_wr(7'h6b, 8'h00, 16'h5f00, 1, nak);
        chk_reg(8'h5f);
        rst_i = 1'b1;
        m.wt(2);
        rst_i = 1'b0;
        m.wt(4);
        chk_reg(8'h17);
        bus_rd(8'h00, 1, r);
        chk("rd_mid", r, 24'h17);
        $display("test refuse done");
    endtask : t_refuse
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    initial begin
        m.wt(6);
        rst_i = 1'b0;
        m.wt(4);
        t_reset();
        t_fields();
        t_multi();
        t_refuse();
        results();
    end
    // Run needs about 0.53 ms
    initial begin
        #2000000;
        n_fail++;
        results();
    end
endmodule : charger_input_limit_regs_bench
`default_nettype wire
